// file: mlu_pkg.sv
/*
 * Shared constants of the move and logic unit: register indices,
 * command field positions, opcodes and reset values.
 * Assumes a 32-bit classic Wishbone bus with word-aligned registers.
 */
package mlu_pkg;

    // ------------------------------------------------------------
    // Word file and register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam int unsigned WORD_W = 16;
    localparam int unsigned FILE_DEPTH = 16;
    localparam int unsigned ADDR_W = 4;
    localparam logic [5:0] IDX_FLAGS = 6'h00;
    localparam logic [5:0] IDX_MINOR = 6'h05;
    localparam logic [5:0] IDX_MATH_LO = 6'h0D;
    localparam logic [5:0] IDX_MATH_HI = 6'h0E;
    localparam logic [5:0] IDX_FILE_LAST = 6'h0F;
    localparam logic [5:0] IDX_CMD = 6'h10;
    localparam logic [5:0] IDX_OPA = 6'h11;
    localparam logic [5:0] IDX_OPB = 6'h12;
    localparam logic [5:0] IDX_MASK = 6'h13;
    localparam logic [5:0] IDX_DEST = 6'h14;
    localparam logic [5:0] IDX_INDEX = 6'h15;
    localparam logic [5:0] IDX_EXEC = 6'h16;
    localparam logic [5:0] IDX_STATUS = 6'h17;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CMD_OP_LSB = 0;
    localparam int unsigned CMD_MA_LSB = 4;
    localparam int unsigned CMD_MB_LSB = 6;
    localparam int unsigned CMD_MM_LSB = 8;
    localparam int unsigned CMD_MD_LSB = 10;
    localparam int unsigned CMD_W = 12;
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_V = 1;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_S = 3;
    localparam int unsigned TRAP_BIT = 0;
    localparam int unsigned EXEC_RUNG = 0;
    localparam int unsigned STAT_CFG = 0;
    localparam int unsigned STAT_MAJOR = 1;

    // ------------------------------------------------------------
    // Operand modes and opcodes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_DIRECT = 2'h0;
    localparam logic [1:0] MODE_INDEXED = 2'h1;
    localparam logic [1:0] MODE_CONST = 2'h2;
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_MOVE = 4'h1;
    localparam logic [3:0] OP_MASKED = 4'h2;
    localparam logic [3:0] OP_AND = 4'h3;
    localparam logic [3:0] OP_OR = 4'h4;
    localparam logic [3:0] OP_COPY1 = 4'h5;
    localparam logic [3:0] OP_END = 4'h6;
    localparam logic [3:0] OP_TEMPEND = 4'h7;
    localparam logic [3:0] OP_UNLATCH = 4'h8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [31:0] RST_BUS = 32'h0000_0000;

endpackage : mlu_pkg

// file: mlu_opnd_res.sv
/*
 * Operand resolver: turns an operand field and its mode into a word
 * file address, or flags it as an immediate constant.
 * Assumes the index register is sampled in the same cycle.
 */
module mlu_opnd_res (
    input wire logic [1:0] mode_i,
    input wire logic [15:0] field_i,
    input wire logic [3:0] index_i,
    output logic [3:0] addr_o,
    output logic const_o
);

    wire logic [3:0] base_w;
    wire logic [3:0] sum_w;

    assign base_w = field_i[3:0];
    // Index wraps inside the file, so no address can escape it
    assign sum_w = 4'(base_w + index_i); // see RQ17
    assign addr_o = (mode_i == mlu_pkg::MODE_INDEXED) ? sum_w : base_w;
    assign const_o = (mode_i == mlu_pkg::MODE_CONST);

endmodule : mlu_opnd_res

// file: mlu_logic_unit.sv
/*
 * Result and flag logic for move, masked move, AND, OR and one-word
 * copy. Purely combinational; the caller decides when it commits.
 */
module mlu_logic_unit (
    input wire logic [3:0] op_i,
    input wire logic [15:0] a_i,
    input wire logic [15:0] b_i,
    input wire logic [15:0] mask_i,
    input wire logic [15:0] dest_i,
    output logic [15:0] res_o,
    output logic [3:0] flags_o,
    output logic upd_flags_o
);

    always_comb begin
        case (op_i)
            mlu_pkg::OP_MOVE: res_o = a_i; // see RQ8
            mlu_pkg::OP_COPY1: res_o = a_i; // see RQ18
            mlu_pkg::OP_MASKED: begin
                res_o = (a_i & mask_i) | (dest_i & ~mask_i); // see RQ10
            end
            mlu_pkg::OP_AND: res_o = a_i & b_i; // see RQ13
            mlu_pkg::OP_OR: res_o = a_i | b_i; // see RQ15
            default: res_o = dest_i;
        endcase
    end

    // Carry and overflow always clear; zero and sign from result
    assign flags_o = {res_o[15], (res_o == 16'h0000), 2'b00}; // see RQ9
    assign upd_flags_o = (op_i == mlu_pkg::OP_MOVE) ||
                         (op_i == mlu_pkg::OP_MASKED) ||
                         (op_i == mlu_pkg::OP_AND) ||
                         (op_i == mlu_pkg::OP_OR); // see RQ12 RQ14 RQ16

endmodule : mlu_logic_unit

// file: mlu_top.sv
/*
 * Move and logic unit with its word file and status words, reached
 * over a classic Wishbone slave with 32-bit data.
 * Assumes a single 100 MHz clock and a synchronous active-low reset;
 * math_fault_i comes from logic on the same clock.
 */
// Operation
// RQ1 - Sources take address or constant; two constant sources are refused
// RQ2 - Destination must be a word address, never a constant
// RQ3 - Four arithmetic flags in low bits of status word zero update
// RQ4 - Math overflow or divide by zero sets the minor trap bit
// RQ5 - Trap still set at end or temporary end raises a major fault
// RQ6 - Unlatch operation clears the trap bit and so prevents the fault
// RQ7 - Move and logic operations never touch the two math words
// RQ8 - Plain move copies source to destination each true scan
// RQ9 - Plain move clears carry, overflow; zero and sign from result
// RQ10 - Masked move passes source where mask one, keeps others
// RQ11 - Mask operand may be a constant or a word address
// RQ12 - Masked move clears carry, overflow; zero, sign from destination
// RQ13 - AND stores bitwise AND of both sources in destination
// RQ14 - AND clears carry, overflow; zero and sign from result
// RQ15 - OR stores bitwise OR of both sources in destination
// RQ16 - OR clears carry, overflow; zero and sign from result
// RQ17 - Any word address operand may be indexed instead
// RQ18 - One-word copy moves data without touching flags
// RQ19 - False rung changes no destination and no flag
// RQ20 - All words are 16 bits, bit 15 gives the sign
module mlu_top (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic math_fault_i,
    output logic major_fault_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0][15:0] word_q;
    logic [11:0] cmd_q;
    logic [15:0] opa_q;
    logic [15:0] opb_q;
    logic [15:0] mask_q;
    logic [15:0] dest_q;
    logic [3:0] index_q;
    logic rung_q;
    logic exec_q;
    logic cfg_err_q;
    logic major_q;
    logic ack_q;
    logic [31:0] dat_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic req_w;
    wire logic wr_w;
    wire logic lo_sel_w;
    wire logic [5:0] idx_w;
    wire logic file_hit_w;
    wire logic [3:0] file_idx_w;
    wire logic [31:0] rd_mux_w;

    assign req_w = wb_cyc_i && wb_stb_i && !ack_q;
    // Registers are 16 bits wide or less, so only the low lanes count
    assign lo_sel_w = wb_sel_i[0] && wb_sel_i[1];
    assign wr_w = req_w && wb_we_i && lo_sel_w;
    assign idx_w = wb_adr_i[7:2];
    assign file_hit_w = (idx_w <= mlu_pkg::IDX_FILE_LAST);
    assign file_idx_w = idx_w[3:0];

    assign rd_mux_w =
        file_hit_w ? {16'h0000, word_q[file_idx_w]} :
        (idx_w == mlu_pkg::IDX_CMD) ? {20'h00000, cmd_q} :
        (idx_w == mlu_pkg::IDX_OPA) ? {16'h0000, opa_q} :
        (idx_w == mlu_pkg::IDX_OPB) ? {16'h0000, opb_q} :
        (idx_w == mlu_pkg::IDX_MASK) ? {16'h0000, mask_q} :
        (idx_w == mlu_pkg::IDX_DEST) ? {16'h0000, dest_q} :
        (idx_w == mlu_pkg::IDX_INDEX) ? {28'h0000000, index_q} :
        (idx_w == mlu_pkg::IDX_EXEC) ? {31'h00000000, rung_q} :
        (idx_w == mlu_pkg::IDX_STATUS) ?
            {30'h00000000, major_q, cfg_err_q} :
        mlu_pkg::RST_BUS;

    // ------------------------------------------------------------
    // Operand resolution
    // ------------------------------------------------------------
    wire logic [3:0] op_w;
    wire logic [3:0] a_addr_w;
    wire logic [3:0] b_addr_w;
    wire logic [3:0] m_addr_w;
    wire logic [3:0] d_addr_w;
    wire logic a_const_w;
    wire logic b_const_w;
    wire logic m_const_w;
    wire logic d_const_w;

    assign op_w = cmd_q[mlu_pkg::CMD_OP_LSB +: 4];

    mlu_opnd_res u_res_a (
        .mode_i(cmd_q[mlu_pkg::CMD_MA_LSB +: 2]),
        .field_i(opa_q),
        .index_i(index_q),
        .addr_o(a_addr_w),
        .const_o(a_const_w)
    );

    mlu_opnd_res u_res_b (
        .mode_i(cmd_q[mlu_pkg::CMD_MB_LSB +: 2]),
        .field_i(opb_q),
        .index_i(index_q),
        .addr_o(b_addr_w),
        .const_o(b_const_w)
    );

    mlu_opnd_res u_res_m (
        .mode_i(cmd_q[mlu_pkg::CMD_MM_LSB +: 2]),
        .field_i(mask_q),
        .index_i(index_q),
        .addr_o(m_addr_w),
        .const_o(m_const_w)
    );

    mlu_opnd_res u_res_d (
        .mode_i(cmd_q[mlu_pkg::CMD_MD_LSB +: 2]),
        .field_i(dest_q),
        .index_i(index_q),
        .addr_o(d_addr_w),
        .const_o(d_const_w)
    );

    wire logic [15:0] a_val_w;
    wire logic [15:0] b_val_w;
    wire logic [15:0] m_val_w;
    wire logic [15:0] d_old_w;

    assign a_val_w = a_const_w ? opa_q : word_q[a_addr_w]; // see RQ1
    assign b_val_w = b_const_w ? opb_q : word_q[b_addr_w];
    assign m_val_w = m_const_w ? mask_q : word_q[m_addr_w]; // see RQ11
    assign d_old_w = word_q[d_addr_w];

    // ------------------------------------------------------------
    // Execution decode
    // ------------------------------------------------------------
    wire logic [15:0] res_w;
    wire logic [3:0] flags_w;
    wire logic upd_flags_w;
    wire logic two_src_w;
    wire logic writes_dest_w;
    wire logic bad_cfg_w;
    wire logic fire_w;
    wire logic end_w;
    wire logic trap_clr_w;
    wire logic wr_dest_w;
    wire logic wr_flags_w;
    wire logic math_dest_w;

    mlu_logic_unit u_logic (
        .op_i(op_w),
        .a_i(a_val_w),
        .b_i(b_val_w),
        .mask_i(m_val_w),
        .dest_i(d_old_w),
        .res_o(res_w),
        .flags_o(flags_w),
        .upd_flags_o(upd_flags_w)
    );

    assign two_src_w = (op_w == mlu_pkg::OP_AND) ||
                       (op_w == mlu_pkg::OP_OR);
    assign writes_dest_w = upd_flags_w || (op_w == mlu_pkg::OP_COPY1);
    // Refused setups do nothing but raise the sticky error
    assign bad_cfg_w = writes_dest_w &&
        ((two_src_w && a_const_w && b_const_w) || // see RQ1
         d_const_w); // see RQ2
    // Ops may never reach the math register words
    assign math_dest_w = (d_addr_w == mlu_pkg::IDX_MATH_LO[3:0]) ||
                         (d_addr_w == mlu_pkg::IDX_MATH_HI[3:0]); // see RQ7
    // A false rung leaves every word alone
    assign fire_w = exec_q && rung_q; // see RQ19
    assign wr_dest_w = fire_w && writes_dest_w && !bad_cfg_w && !math_dest_w;
    assign wr_flags_w = fire_w && upd_flags_w && !bad_cfg_w; // see RQ3
    assign end_w = fire_w && ((op_w == mlu_pkg::OP_END) ||
                              (op_w == mlu_pkg::OP_TEMPEND));
    assign trap_clr_w = fire_w && (op_w == mlu_pkg::OP_UNLATCH);

    // ------------------------------------------------------------
    // Bus side registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
            dat_q <= mlu_pkg::RST_BUS;
        end else begin
            ack_q <= req_w;
            if (req_w) begin
                dat_q <= rd_mux_w;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cmd_q <= 12'h000;
            opa_q <= mlu_pkg::RST_WORD;
            opb_q <= mlu_pkg::RST_WORD;
            mask_q <= mlu_pkg::RST_WORD;
            dest_q <= mlu_pkg::RST_WORD;
            index_q <= 4'h0;
            rung_q <= 1'b0;
            exec_q <= 1'b0;
        end else begin
            exec_q <= wr_w && (idx_w == mlu_pkg::IDX_EXEC);
            if (wr_w) begin
                case (idx_w)
                    mlu_pkg::IDX_CMD: cmd_q <= wb_dat_i[11:0];
                    mlu_pkg::IDX_OPA: opa_q <= wb_dat_i[15:0];
                    mlu_pkg::IDX_OPB: opb_q <= wb_dat_i[15:0];
                    mlu_pkg::IDX_MASK: mask_q <= wb_dat_i[15:0];
                    mlu_pkg::IDX_DEST: dest_q <= wb_dat_i[15:0];
                    mlu_pkg::IDX_INDEX: index_q <= wb_dat_i[3:0];
                    mlu_pkg::IDX_EXEC: begin
                        rung_q <= wb_dat_i[mlu_pkg::EXEC_RUNG];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Word file and status words
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            word_q <= '0;
        end else begin
            if (wr_w && file_hit_w) begin
                word_q[file_idx_w] <= wb_dat_i[15:0];
            end
            if (wr_dest_w) begin
                word_q[d_addr_w] <= res_w; // see RQ2 RQ20
            end
            // Flags land last, so they win if the destination is word 0
            if (wr_flags_w) begin
                word_q[0][3:0] <= flags_w; // see RQ3 RQ9 RQ12
            end
            if (trap_clr_w) begin
                word_q[5][mlu_pkg::TRAP_BIT] <= 1'b0; // see RQ6
            end
            // Set wins over any clear in the same cycle
            if (math_fault_i) begin
                word_q[5][mlu_pkg::TRAP_BIT] <= 1'b1; // see RQ4
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky error and fault
    // ------------------------------------------------------------
    wire logic stat_wr_w;

    assign stat_wr_w = wr_w && (idx_w == mlu_pkg::IDX_STATUS);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cfg_err_q <= 1'b0;
            major_q <= 1'b0;
        end else begin
            if (stat_wr_w && wb_dat_i[mlu_pkg::STAT_CFG]) begin
                cfg_err_q <= 1'b0;
            end
            if (fire_w && bad_cfg_w) begin
                cfg_err_q <= 1'b1; // see RQ1 RQ2
            end
            if (stat_wr_w && wb_dat_i[mlu_pkg::STAT_MAJOR]) begin
                major_q <= 1'b0;
            end
            if (end_w && word_q[5][mlu_pkg::TRAP_BIT]) begin
                major_q <= 1'b1; // see RQ5
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign major_fault_o = major_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_unlatch;
        fire_w && (op_w == mlu_pkg::OP_UNLATCH) && !math_fault_i;
    endsequence

    property p_two_const;
        fire_w && two_src_w && a_const_w && b_const_w && !math_fault_i
            |=> cfg_err_q && $stable(word_q);
    endproperty
    a_two_const: assert property (p_two_const) // see RQ1
        else $error("two constant sources were accepted");

    property p_const_dest;
        fire_w && writes_dest_w && d_const_w && !math_fault_i
            |=> cfg_err_q && $stable(word_q);
    endproperty
    a_const_dest: assert property (p_const_dest) // see RQ2
        else $error("constant destination was written");

    property p_move_flags;
        wr_flags_w && !(wr_w && file_hit_w)
            |=> word_q[0][3:0] == {$past(res_w[15]),
                                   $past(res_w) == 16'h0000, 2'b00};
    endproperty
    a_move_flags: assert property (p_move_flags) // see RQ3
        else $error("flags do not match the result");

    property p_trap_set;
        math_fault_i |=> word_q[5][mlu_pkg::TRAP_BIT];
    endproperty
    a_trap_set: assert property (p_trap_set) // see RQ4
        else $error("trap bit not set by math fault");

    property p_major;
        end_w && word_q[5][mlu_pkg::TRAP_BIT] |=> major_q ##1 major_q || stat_wr_w;
    endproperty
    a_major: assert property (p_major) // see RQ5
        else $error("major fault missing at end");

    property p_unlatch;
        s_unlatch |=> !word_q[5][mlu_pkg::TRAP_BIT];
    endproperty
    a_unlatch: assert property (p_unlatch) // see RQ6
        else $error("trap bit survived unlatch");

    property p_math_reg;
        exec_q |=> $stable(word_q[13]) && $stable(word_q[14]);
    endproperty
    a_math_reg: assert property (p_math_reg) // see RQ7
        else $error("math register changed by an operation");

    property p_move_data;
        wr_dest_w && (op_w == mlu_pkg::OP_MOVE) && d_addr_w != 4'h0
            |=> word_q[$past(d_addr_w)] == $past(a_val_w);
    endproperty
    a_move_data: assert property (p_move_data) // see RQ8
        else $error("move did not copy the source");

    property p_masked;
        wr_dest_w && (op_w == mlu_pkg::OP_MASKED) && d_addr_w != 4'h0
            |=> ((word_q[$past(d_addr_w)] ^ $past(d_old_w)) &
                 ~$past(m_val_w)) == 16'h0000;
    endproperty
    a_masked: assert property (p_masked) // see RQ10
        else $error("masked move altered a masked bit");

    property p_and_or;
        wr_dest_w && two_src_w && d_addr_w != 4'h0
            |=> word_q[$past(d_addr_w)] ==
                (($past(op_w) == mlu_pkg::OP_AND) ?
                 ($past(a_val_w) & $past(b_val_w)) :
                 ($past(a_val_w) | $past(b_val_w)));
    endproperty
    a_and_or: assert property (p_and_or) // see RQ13 RQ15
        else $error("logic result wrong");

    property p_copy_flags;
        fire_w && (op_w == mlu_pkg::OP_COPY1) && d_addr_w != 4'h0 &&
        !(wr_w && file_hit_w) |=> $stable(word_q[0][3:0]);
    endproperty
    a_copy_flags: assert property (p_copy_flags) // see RQ18
        else $error("one-word copy touched the flags");

    property p_rung_false;
        exec_q && !rung_q && !math_fault_i |=> $stable(word_q);
    endproperty
    a_rung_false: assert property (p_rung_false) // see RQ19
        else $error("false rung changed a word");

endmodule : mlu_top

// file: move_and_logic_unit_tb.sv
/*
 * Self-checking bench for the move and logic unit: drives the Wishbone
 * slave and the math fault input, queues expected read data, and a
 * monitor compares each read answer with the oldest queued value.
 * Assumes the mlu_top ports and the mlu_pkg constants as delivered.
 */
module move_and_logic_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------
    logic sys_clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, math_fault_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic wb_ack_o, major_fault_o;
    int fail_count = 0;
    int n_tests = 0;
    int cyc_n = 0;
    int seed;
    logic [31:0] exp_q[$];
    logic [15:0] a, b, m, d, r;
    logic [3:0] op;
    logic [3:0] ops[5];

    mlu_top uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .math_fault_i(math_fault_i), .major_fault_o(major_fault_o));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("compares %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report

    // Request is still held at the ack edge, so we_i marks a read
    always @(posedge sys_clk_i) begin
        if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i && exp_q.size() > 0)
            chk(wb_dat_o, exp_q.pop_front());
        cyc_n++;
        if (cyc_n == 5000) begin
            fail_count++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic xfer(input logic [5:0] idx, input logic we,
                        input logic [31:0] dat, input logic [3:0] sel);
        @(posedge sys_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [5:0] idx, input logic [15:0] v);
        xfer(idx, 1'b1, {16'h0000, v}, 4'hF);
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
        exp_q.push_back(exp);
        xfer(idx, 1'b0, 32'h0000_0000, 4'hF);
    endtask : rd

    function automatic logic [11:0] mk(input logic [3:0] o,
        input logic [1:0] ma, mb, mm, md);
        return {md, mm, mb, ma, o};
    endfunction : mk

    task automatic run(input logic [11:0] cmd, input logic [15:0] fa, fb,
                       input logic [15:0] fm, fd, input logic rung);
        wr(mlu_pkg::IDX_CMD, {4'h0, cmd});
        wr(mlu_pkg::IDX_OPA, fa);
        wr(mlu_pkg::IDX_OPB, fb);
        wr(mlu_pkg::IDX_MASK, fm);
        wr(mlu_pkg::IDX_DEST, fd);
        wr(mlu_pkg::IDX_EXEC, {15'h0000, rung});
    endtask : run

    task automatic fault_pulse;
        @(posedge sys_clk_i);
        math_fault_i <= 1'b1;
        @(posedge sys_clk_i);
        math_fault_i <= 1'b0;
    endtask : fault_pulse

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 76522;
        ops = '{mlu_pkg::OP_MOVE, mlu_pkg::OP_MASKED, mlu_pkg::OP_AND,
                mlu_pkg::OP_OR, mlu_pkg::OP_COPY1};
        {wb_cyc_i, wb_stb_i, wb_we_i, math_fault_i} = 4'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        rst_n_i = 1'b0;
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 16; i++) rd(6'(i), 32'h0000_0000);
        rd(mlu_pkg::IDX_STATUS, 32'h0000_0000);
        chk({31'h0, major_fault_o}, 32'h0000_0000);
        // Partial byte enables and unmapped space must be ignored
        xfer(6'h01, 1'b1, 32'h0000_1234, 4'h1);
        rd(6'h01, 32'h0000_0000);
        wr(6'h18, 16'hFFFF);
        rd(6'h18, 32'h0000_0000);
        // Each op twice: random, then zero source A, which forces the zero flag for move and AND
        for (int i = 0; i < 10; i++) begin
            a = 16'($random(seed));
            b = 16'($random(seed));
            m = 16'($random(seed));
            d = 16'($random(seed));
            if (i >= 5) a = 16'h0000;
            op = ops[i % 5];
            wr(6'h01, a);
            wr(6'h02, b);
            wr(6'h03, m);
            wr(6'h04, d);
            wr(6'h00, 16'hA003);
            wr(6'h0D, ~a);
            wr(6'h0E, ~b);
            case (op)
                mlu_pkg::OP_MASKED: r = (a & m) | (d & ~m);
                mlu_pkg::OP_AND: r = a & b;
                mlu_pkg::OP_OR: r = a | b;
                default: r = a;
            endcase
            run(mk(op, 2'h0, 2'h0, 2'h0, 2'h0), 16'h0001, 16'h0002,
                16'h0003, 16'h0004, 1'b1);
            rd(6'h04, {16'h0000, r});
            rd(6'h00, (op == mlu_pkg::OP_COPY1) ? 32'h0000_A003 :
               {16'h0000, 12'hA00, r[15], r == 16'h0000, 2'b00});
            rd(6'h0D, {16'h0000, ~a});
            rd(6'h0E, {16'h0000, ~b});
        end
        // False rung leaves destination and flags alone; a true move cannot write math word 13
        wr(6'h04, 16'h1357);
        wr(6'h00, 16'h000F);
        run(mk(mlu_pkg::OP_MOVE, 2'h0, 2'h0, 2'h0, 2'h0), 16'h0001, 16'h0000,
            16'h0000, 16'h0004, 1'b0);
        rd(6'h04, 32'h0000_1357);
        rd(6'h00, 32'h0000_000F);
        run(mk(mlu_pkg::OP_MOVE, 2'h0, 2'h0, 2'h0, 2'h0), 16'h0001, 16'h0000,
            16'h0000, 16'h000D, 1'b1);
        rd(6'h0D, {16'h0000, ~a});
        // Constant mask, indexed destination (3 + 3 = word 6)
        wr(6'h01, 16'h5555);
        wr(6'h06, 16'hFFFF);
        wr(mlu_pkg::IDX_INDEX, 16'h0003);
        run(mk(mlu_pkg::OP_MASKED, 2'h0, 2'h0, mlu_pkg::MODE_CONST,
            mlu_pkg::MODE_INDEXED), 16'h0001, 16'h0000, 16'hF0F0,
            16'h0003, 1'b1);
        rd(6'h06, 32'h0000_5F5F);
        rd(6'h00, 32'h0000_0000);
        // Constant A, indexed B (8 -> 11), destination wraps 14 -> 1
        wr(6'h0B, 16'h8F0F);
        run(mk(mlu_pkg::OP_AND, mlu_pkg::MODE_CONST, mlu_pkg::MODE_INDEXED,
            2'h0, mlu_pkg::MODE_INDEXED), 16'hF00F, 16'h0008, 16'h0000,
            16'h000E, 1'b1);
        rd(6'h01, 32'h0000_800F);
        rd(6'h00, 32'h0000_0008);
        // OR with constant B giving zero
        wr(6'h02, 16'h0000);
        wr(6'h07, 16'hFFFF);
        run(mk(mlu_pkg::OP_OR, 2'h0, mlu_pkg::MODE_CONST, 2'h0, 2'h0),
            16'h0002, 16'h0000, 16'h0000, 16'h0007, 1'b1);
        rd(6'h07, 32'h0000_0000);
        rd(6'h00, 32'h0000_0004);
        // Two constant sources, then constant destination: refused
        wr(6'h07, 16'h2468);
        run(mk(mlu_pkg::OP_AND, mlu_pkg::MODE_CONST, mlu_pkg::MODE_CONST,
            2'h0, 2'h0), 16'h0001, 16'h0002, 16'h0000, 16'h0007, 1'b1);
        rd(6'h07, 32'h0000_2468);
        rd(mlu_pkg::IDX_STATUS, 32'h0000_0001);
        wr(mlu_pkg::IDX_STATUS, 16'h0001);
        rd(mlu_pkg::IDX_STATUS, 32'h0000_0000);
        run(mk(mlu_pkg::OP_MOVE, 2'h0, 2'h0, 2'h0, mlu_pkg::MODE_CONST),
            16'h0001, 16'h0000, 16'h0000, 16'h0007, 1'b1);
        rd(6'h07, 32'h0000_2468);
        rd(mlu_pkg::IDX_STATUS, 32'h0000_0001);
        wr(mlu_pkg::IDX_STATUS, 16'h0001);
        // Trap: false-rung end ignored, true end faults, unlatch saves
        fault_pulse();
        rd(6'h05, 32'h0000_0001);
        run(mk(mlu_pkg::OP_END, 2'h0, 2'h0, 2'h0, 2'h0), 16'h0000, 16'h0000,
            16'h0000, 16'h0000, 1'b0);
        rd(mlu_pkg::IDX_STATUS, 32'h0000_0000);
        wr(mlu_pkg::IDX_EXEC, 16'h0001);
        rd(mlu_pkg::IDX_STATUS, 32'h0000_0002);
        chk({31'h0, major_fault_o}, 32'h0000_0001);
        wr(mlu_pkg::IDX_STATUS, 16'h0002);
        run(mk(mlu_pkg::OP_UNLATCH, 2'h0, 2'h0, 2'h0, 2'h0), 16'h0000,
            16'h0000, 16'h0000, 16'h0000, 1'b1);
        rd(6'h05, 32'h0000_0000);
        run(mk(mlu_pkg::OP_TEMPEND, 2'h0, 2'h0, 2'h0, 2'h0), 16'h0000,
            16'h0000, 16'h0000, 16'h0000, 1'b1);
        rd(mlu_pkg::IDX_STATUS, 32'h0000_0000);
        chk({31'h0, major_fault_o}, 32'h0000_0000);
        fault_pulse();
        wr(mlu_pkg::IDX_EXEC, 16'h0001);
        rd(mlu_pkg::IDX_STATUS, 32'h0000_0002);
        repeat (4) @(posedge sys_clk_i);
        final_report();
    end
endmodule : move_and_logic_unit_tb
